/* File: converter_latch_model.sv */
// behavioural model of the converter's two-stage digital input latches
// assumes the controller's pins wired directly; bus16 selects the wiring
`timescale 1ns/1ps
`default_nettype none
module converter_latch_model (
    input  wire logic [15:0] data_out,
    input  wire logic        chip_select_n,
    input  wire logic        input_write_strobe_n,
    input  wire logic        register_write_strobe_n,
    input  wire logic        transfer_strobe_n,
    input  wire logic        byte_select,
    input  wire logic        justify_select,
    input  wire logic        bus16,
    output logic [9:0]       input_word,
    output logic [9:0]       dac_word
);
    logic [9:0] pin_word;

    // route bus lines onto the ten latch inputs
    always_comb begin
        if (bus16) begin
            pin_word = justify_select ? data_out[15:6] : data_out[9:0];
        end else if (justify_select) begin
            pin_word = {data_out[7:0], data_out[7:6]};
        end else begin
            pin_word = {data_out[1:0], data_out[7:0]};
        end
    end

    // input latch: open while select and first write are low
    always_latch begin
        if (!chip_select_n && !input_write_strobe_n) begin
            if (byte_select) begin
                input_word <= pin_word;
            end else if (justify_select) begin
                input_word[1:0] <= pin_word[1:0];
            end else begin
                input_word[9:8] <= pin_word[9:8];
            end
        end
    end

    // dac register: open while both transfer strobes are low; both open
    // together gives flow-through, and the word drives the switches
    always_latch begin
        if (!register_write_strobe_n && !transfer_strobe_n) begin
            dac_word <= input_word;
        end
    end
endmodule : converter_latch_model
`default_nettype wire

/* File: dac_host_ctrl.sv */
// host controller that loads a double-buffered 10-bit converter
// assumes an apb master on pclk and the converter pins wired directly
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - on 8-bit bus send two writes
// - right: low byte first; left: high first
// - justify pin high left, low right
// - left-only part takes high byte first
// - auto only when update timing is loose
// - synchronized update by shared transfer strobe
// - unused six bus bits are don't care
// - host mode: third write strobes transfer
// - 16-bit bus keeps byte select high
module dac_host_ctrl
    import dac_host_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic [15:0]      data_out,
    output logic             chip_select_n,
    output logic             input_write_strobe_n,
    output logic             register_write_strobe_n,
    output logic             transfer_strobe_n,
    output logic             byte_select,
    output logic             justify_select
);

    // bus value of one write: whole word on 16 bits, else one byte
    function automatic logic [15:0] bus_value(input logic [9:0] w,
                                              input logic left,
                                              input logic bus16,
                                              input logic first);
        logic [15:0] v;
        v = 16'h0000;
        if (bus16) begin
            v = left ? {w, 6'h00} : {6'h00, w};
        end else if (left) begin
            v = first ? {8'h00, w[9:2]} : {8'h00, w[1:0], 6'h00};
        end else begin
            v = first ? {8'h00, w[7:0]} : {14'h0000, w[9:8]};
        end
        return v;
    endfunction : bus_value

    logic [3:0]  ctrl_q;
    logic [9:0]  word_q;
    logic        mode_err_q;
    logic        refused_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    state_type   state_q;
    logic        cmd_transfer_strobe_n_q;
    logic        idx_q;
    logic        left_q;
    logic        bus16_q;
    mode_type    mode_q;
    logic [15:0] data_q;
    logic        cs_n_q;
    logic        wr1_n_q;
    logic        wr2_n_q;
    logic        transfer_strobe_n_n_q;
    logic        bsel_q;
    logic        just_q;
    logic        tick;
    logic        busy;
    logic        take;
    logic        wr_fire;
    logic        mapped;
    logic        start_load;
    logic        start_transfer_strobe_n;
    logic        last_idx;
    logic        transfer_strobe_n_now;
    mode_type    ctrl_mode;

    assign ctrl_mode = mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
    assign busy      = (state_q != ST_IDLE);
    assign take      = psel && penable && !pready_q;
    assign wr_fire   = psel && penable && pready_q && pwrite;
    assign mapped    = (paddr == CTRL_ADDR) || (paddr == DATA_ADDR) ||
                       (paddr == STATUS_ADDR) || (paddr == TRANSFER_STROBE_N_ADDR);
    // flow-through is never driven from the bus
    assign start_load = wr_fire && paddr == DATA_ADDR && !busy &&
                        ctrl_mode != MODE_FLOW;
    assign start_transfer_strobe_n = wr_fire && paddr == TRANSFER_STROBE_N_ADDR && !busy &&
                        ctrl_mode != MODE_FLOW;
    // 8-bit loads take two writes, 16-bit loads and transfers one
    assign last_idx  = !cmd_transfer_strobe_n_q && !bus16_q;
    // auto mode strobes the transfer with the final load write
    assign transfer_strobe_n_now  = cmd_transfer_strobe_n_q ||
                       (mode_q == MODE_AUTO && idx_q == last_idx);

    phase_divider u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .run     (busy),
        .tick    (tick)
    );

    // apb answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= take;
            pslverr_q <= take && !mapped;
            if (take && !pwrite) begin
                if (paddr == CTRL_ADDR) begin
                    prdata_q <= {28'h0000000, ctrl_q};
                end else if (paddr == DATA_ADDR) begin
                    prdata_q <= {22'h000000, word_q};
                end else if (paddr == STATUS_ADDR) begin
                    prdata_q <= {29'h00000000, refused_q, mode_err_q,
                                 busy};
                end else begin
                    prdata_q <= 32'h0000_0000;
                end
            end
        end
    end

    // control and data registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= CTRL_RESET;
            word_q <= DATA_RESET;
        end else if (wr_fire && paddr == CTRL_ADDR) begin
            ctrl_q <= pwdata[3:0];
        end else if (start_load) begin
            word_q <= pwdata[9:0];
        end
    end

    // sticky status: a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_err_q <= 1'b0;
            refused_q  <= 1'b0;
        end else begin
            if (wr_fire && (paddr == DATA_ADDR || paddr == TRANSFER_STROBE_N_ADDR) &&
                !busy && ctrl_mode == MODE_FLOW) begin
                mode_err_q <= 1'b1;
            end else if (wr_fire && paddr == STATUS_ADDR &&
                         pwdata[STAT_MODE_ERR_BIT]) begin
                mode_err_q <= 1'b0;
            end
            if (wr_fire && (paddr == DATA_ADDR || paddr == TRANSFER_STROBE_N_ADDR) &&
                busy) begin
                refused_q <= 1'b1;
            end else if (wr_fire && paddr == STATUS_ADDR &&
                         pwdata[STAT_REFUSED_BIT]) begin
                refused_q <= 1'b0;
            end
        end
    end

    // snapshot of the command so control writes cannot upset it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_transfer_strobe_n_q <= 1'b0;
            left_q     <= 1'b0;
            bus16_q    <= 1'b0;
            mode_q     <= MODE_AUTO;
        end else if (start_load || start_transfer_strobe_n) begin
            cmd_transfer_strobe_n_q <= start_transfer_strobe_n;
            left_q     <= ctrl_q[CTRL_LEFT_BIT];
            bus16_q    <= ctrl_q[CTRL_BUS16_BIT];
            mode_q     <= ctrl_mode;
        end
    end

    // write sequencer: setup, strobe, hold per write, then recovery
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            idx_q   <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    idx_q <= 1'b0;
                    if (start_load || start_transfer_strobe_n) begin
                        state_q <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (tick) begin
                        state_q <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    if (tick) begin
                        state_q <= ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (tick && idx_q != last_idx) begin
                        idx_q   <= 1'b1;
                        state_q <= ST_SETUP;
                    end else if (tick) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (tick) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // converter pins, all registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_q   <= 16'h0000;
            cs_n_q   <= 1'b1;
            wr1_n_q  <= 1'b1;
            wr2_n_q  <= 1'b1;
            transfer_strobe_n_n_q <= 1'b1;
            bsel_q   <= 1'b1;
        end else begin
            if (state_q == ST_IDLE && start_load) begin
                cs_n_q <= 1'b0;
                // first write carries the byte that fills all ten bits
                data_q <= bus_value(pwdata[9:0], ctrl_q[CTRL_LEFT_BIT],
                                    ctrl_q[CTRL_BUS16_BIT], 1'b1);
                bsel_q <= 1'b1;
            end else if (state_q == ST_IDLE && start_transfer_strobe_n) begin
                cs_n_q <= 1'b0;
                bsel_q <= 1'b1;
            end else if (state_q == ST_SETUP && tick) begin
                wr1_n_q  <= cmd_transfer_strobe_n_q;
                wr2_n_q  <= !transfer_strobe_n_now;
                transfer_strobe_n_n_q <= !transfer_strobe_n_now;
            end else if (state_q == ST_STROBE && tick) begin
                // releasing the strobes closes the latches
                wr1_n_q  <= 1'b1;
                wr2_n_q  <= 1'b1;
                transfer_strobe_n_n_q <= 1'b1;
            end else if (state_q == ST_HOLD && tick) begin
                if (idx_q != last_idx) begin
                    data_q <= bus_value(word_q, left_q, 1'b0, 1'b0);
                    bsel_q <= 1'b0;
                end else begin
                    cs_n_q <= 1'b1;
                    bsel_q <= 1'b1;
                end
            end
        end
    end

    // justification pin follows control, frozen during a sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            just_q <= 1'b0;
        end else if (!busy) begin
            just_q <= ctrl_q[CTRL_LEFT_BIT];
        end
    end

    assign prdata                  = prdata_q;
    assign pready                  = pready_q;
    assign pslverr                 = pslverr_q;
    assign data_out                = data_q;
    assign chip_select_n           = cs_n_q;
    assign input_write_strobe_n    = wr1_n_q;
    assign register_write_strobe_n = wr2_n_q;
    assign transfer_strobe_n       = transfer_strobe_n_n_q;
    assign byte_select             = bsel_q;
    assign justify_select          = just_q;

    // each strobe lasts a full step
    strobe_width_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        $fell(chip_select_n | (input_write_strobe_n &
              register_write_strobe_n)) |->
        (!(input_write_strobe_n & register_write_strobe_n))[*3]
    ) else $error("strobe shorter than one step");

    // data stays put while the input write strobe is low
    data_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!input_write_strobe_n && $past(!input_write_strobe_n)) |->
        $stable(data_out)
    ) else $error("data moved under write strobe");

    // first load write has byte select high and the ordered byte
    first_byte_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_STROBE && !idx_q && !cmd_transfer_strobe_n_q) |->
        (byte_select &&
         data_out == bus_value(word_q, left_q, bus16_q, 1'b1))
    ) else $error("first write carries wrong byte");

    // an 8-bit load issues a second write with byte select low
    two_writes_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (start_load && !ctrl_q[CTRL_BUS16_BIT]) |->
        ##[1:20] (!input_write_strobe_n && !byte_select)
    ) else $error("second byte write missing");

    // auto mode transfers together with the last load write
    auto_transfer_strobe_n_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (state_q == ST_STROBE && mode_q == MODE_AUTO && !cmd_transfer_strobe_n_q &&
         idx_q == last_idx) |->
        (!input_write_strobe_n && !register_write_strobe_n &&
         !transfer_strobe_n)
    ) else $error("auto transfer not strobed");

    // a transfer command strobes only the register path
    transfer_strobe_n_cmd_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        start_transfer_strobe_n |-> ##4 (input_write_strobe_n &&
                            !register_write_strobe_n &&
                            !transfer_strobe_n && !chip_select_n)
    ) else $error("transfer command strobes wrong");

    // 16-bit bus: byte select high, unused bits zero
    bus16_pins_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (busy && bus16_q && !cmd_transfer_strobe_n_q && state_q != ST_SETUP) |->
        (byte_select && (left_q ? data_out[5:0] == 6'h00 :
                                  data_out[15:10] == 6'h00))
    ) else $error("16-bit write pins wrong");

    // flow-through request never reaches the pins
    no_flow_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && !busy && ctrl_mode == MODE_FLOW &&
         (paddr == DATA_ADDR || paddr == TRANSFER_STROBE_N_ADDR)) |=>
        (!busy && mode_err_q)
    ) else $error("flow-through request not refused");

    // justification pin never changes during a sequence
    justify_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (busy && $past(busy)) |-> $stable(justify_select)
    ) else $error("justify pin moved mid sequence");

    // apb answers in the second access cycle
    apb_answer_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        take |=> pready
    ) else $error("apb answer late");

endmodule : dac_host_ctrl
`default_nettype wire

/* File: dac_host_ctrl_tb_top.sv */
// self-checking bench for the converter host controller
// assumes the latch model on the pins and an apb master in this bench
`timescale 1ns/1ps
`default_nettype none
module dac_host_ctrl_tb_top;
    import dac_host_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic        bus16 = 0, err;
    wire  [31:0] prdata;
    wire         pready, pslverr, cs_n, wr1_n, wr2_n, xf_n, bsel, just;
    wire  [15:0] data_out;
    wire  [9:0]  input_word, dac_word;
    int          miscompares = 0, cmp_count = 0, cycles = 0;
    logic [9:0]  w;

    dac_host_ctrl i_dac_host_ctrl (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .data_out(data_out), .chip_select_n(cs_n),
        .input_write_strobe_n(wr1_n), .register_write_strobe_n(wr2_n),
        .transfer_strobe_n(xf_n), .byte_select(bsel),
        .justify_select(just));
    converter_latch_model i_converter_latch_model (.data_out(data_out),
        .chip_select_n(cs_n), .input_write_strobe_n(wr1_n),
        .register_write_strobe_n(wr2_n), .transfer_strobe_n(xf_n),
        .byte_select(bsel), .justify_select(just), .bus16(bus16),
        .input_word(input_word), .dac_word(dac_word));

    // clock and hang guard
    initial begin
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            miscompares = miscompares + 1;
            close_out();
        end
    end

    task automatic close_out();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string msg);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch %0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask : check

    // one apb transfer: setup, access until pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // poll status until the pin sequence is over
    task automatic wait_idle();
        for (int i = 0; i < 60; i++) begin
            apb(1'b0, STATUS_ADDR, 32'h0);
            if (rd[STAT_BUSY_BIT] === 1'b0) begin
                return;
            end
        end
        check(1'b1, 1'b0, "busy stuck");
    endtask : wait_idle

    task automatic set_ctrl(input logic [1:0] m, input logic b, input logic l);
        apb(1'b1, CTRL_ADDR, (32'(m) << CTRL_MODE_LSB) |
            (32'(b) << CTRL_BUS16_BIT) | (32'(l) << CTRL_LEFT_BIT));
        bus16 <= b;
    endtask : set_ctrl

    task automatic load(input logic [9:0] v);
        apb(1'b1, DATA_ADDR, {22'h0, v});
        wait_idle();
    endtask : load

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        check({cs_n, wr1_n, wr2_n, xf_n, bsel, just}, 6'h3E, "reset pins");
        apb(1'b0, CTRL_ADDR, 32'h0);
        check(rd, {28'h0, CTRL_RESET}, "ctrl reset");
        apb(1'b0, DATA_ADDR, 32'h0);
        check(rd, {22'h0, DATA_RESET}, "data reset");
        // automatic transfer for every bus width and justification
        for (int i = 0; i < 4; i++) begin
            w = 10'h2A5 ^ 10'(i * 10'h0C3);
            set_ctrl(MODE_AUTO, i[1], i[0]);
            load(w);
            check(dac_word, w, "auto dac");
            check(input_word, w, "auto latch");
            check(just, i[0], "justify pin");
            apb(1'b0, DATA_ADDR, 32'h0);
            check(rd, {22'h0, w}, "data readback");
        end
        // host-strobed double buffering, then shared transfer
        for (int b = 0; b < 2; b++) begin
            w = 10'h13C + 10'(b);
            set_ctrl(MODE_HOST, b[0], b[0]);
            load(w);
            check(input_word, w, "host latch");
            check(dac_word !== w, 1'b1, "host held");
            apb(1'b1, TRANSFER_STROBE_N_ADDR, 32'h0);
            wait_idle();
            check(dac_word, w, "host transfer_strobe_n");
        end
        // external mode loads without transfer
        set_ctrl(MODE_EXTERNAL, 1'b0, 1'b1);
        load(10'h3FF);
        check(input_word, 10'h3FF, "ext latch");
        check(dac_word, w, "ext held");
        // flow-through refused, error flag w1c
        set_ctrl(MODE_FLOW, 1'b1, 1'b0);
        load(10'h001);
        check(dac_word, w, "flow ignored");
        check(rd[STAT_MODE_ERR_BIT], 1'b1, "mode err");
        apb(1'b1, STATUS_ADDR, 32'h2);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(rd, 32'h0, "mode err clear");
        // write while busy is refused
        set_ctrl(MODE_AUTO, 1'b0, 1'b0);
        apb(1'b1, DATA_ADDR, 32'h155);
        apb(1'b1, DATA_ADDR, 32'h2AA);
        wait_idle();
        check(dac_word, 10'h155, "busy write");
        check(rd[STAT_REFUSED_BIT], 1'b1, "refused flag");
        apb(1'b1, STATUS_ADDR, 32'h4);
        apb(1'b0, STATUS_ADDR, 32'h0);
        check(rd, 32'h0, "refused clear");
        // unmapped address
        apb(1'b0, 8'h10, 32'h0);
        check({err, rd}, {1'b1, 32'h0}, "unmapped");
        close_out();
    end
endmodule : dac_host_ctrl_tb_top
`default_nettype wire

/* File: dac_host_pkg.sv */
// constants, field layouts and types shared by the converter host controller
// assumes a 20 MHz pclk and a 32-bit apb register bus
package dac_host_pkg;

    // converter word and pin widths
    localparam int WORD_WIDTH = 10;
    localparam int BUS_WIDTH  = 16;
    localparam int PAD_WIDTH  = BUS_WIDTH - WORD_WIDTH;

    // register byte offsets
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] DATA_ADDR   = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] TRANSFER_STROBE_N_ADDR   = 8'h0C;

    // control field positions
    localparam int CTRL_LEFT_BIT  = 0;
    localparam int CTRL_BUS16_BIT = 1;
    localparam int CTRL_MODE_LSB  = 2;

    // status field positions
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_MODE_ERR_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;

    // reset values
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [9:0] DATA_RESET = 10'h000;

    // strobe phase timing: setup, strobe and hold each last one step
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int STEP_NS         = 150;
    localparam int STEP_CYCLES     =
        (STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // transfer modes; on a 16-bit bus auto means single-buffered
    typedef enum logic [1:0] {
        MODE_AUTO     = 2'b00,
        MODE_HOST     = 2'b01,
        MODE_EXTERNAL = 2'b10,
        MODE_FLOW     = 2'b11
    } mode_type;

    // write sequencer, gray coded from idle through done; hold to setup and done to idle flip two bits
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b011,
        ST_HOLD   = 3'b010,
        ST_DONE   = 3'b110
    } state_type;

endpackage : dac_host_pkg

/* File: phase_divider.sv */
// step enable for the pin sequencer: one-cycle tick every step
// assumes run stays high for the whole write sequence
`timescale 1ns/1ps
`default_nettype none
module phase_divider
    import dac_host_pkg::*;
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic run,
    output logic      tick
);

    logic [1:0] count_q;

    // tick on the last cycle of each step
    assign tick = run && (count_q == 2'(STEP_CYCLES - 1));

    // count restarts whenever the sequencer is idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= 2'h0;
        end else if (!run || tick) begin
            count_q <= 2'h0;
        end else begin
            count_q <= count_q + 2'h1;
        end
    end

endmodule : phase_divider
`default_nettype wire
